// ---- verilog/atsap_port.sv ----
// Slave access port into four local RAMs (two per processor).
// Assumes RAM ports with one-cycle read latency; core traffic raises ram_core_busy.
module atsap_port #(
  parameter int ID_W       = 4,
  parameter int ADDR_W     = 32,
  parameter int RAM_AW     = 13,
  parameter bit P1_PRESENT = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic [ID_W-1:0]   awid,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [3:0]        awlen,
  input  wire logic [2:0]        awsize,
  input  wire logic [1:0]        awburst,
  input  wire logic [1:0]        write_target_select,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [63:0]       wdata,
  input  wire logic [7:0]        wstrb,
  input  wire logic              wlast,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [ID_W-1:0]        bid,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ID_W-1:0]   arid,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [3:0]        arlen,
  input  wire logic [2:0]        arsize,
  input  wire logic [1:0]        arburst,
  input  wire logic [1:0]        read_target_select,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [ID_W-1:0]        rid,
  output logic [63:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rlast,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [3:0]        ram_core_busy,
  output logic [3:0]             ram_en,
  output logic [3:0]             ram_we,
  output logic [RAM_AW-4:0]      ram_addr,
  output logic [63:0]            ram_wdata,
  output logic [7:0]             ram_wstrb,
  input  wire logic [63:0]       ram_rdata0,
  input  wire logic [63:0]       ram_rdata1,
  input  wire logic [63:0]       ram_rdata2,
  input  wire logic [63:0]       ram_rdata3
);
  // ------------------------------------------------------------
  // Access checks
  // ------------------------------------------------------------
  // Lock, cache and protection are not ports at all, so none of them is checked
  function automatic logic acc_ok(input logic [ADDR_W-1:0] a, input logic [3:0] len,
                                  input logic [2:0] sz, input logic [1:0] sel);
    logic ok;
    ok = 1'b0;
    unique case (sz)
      atsap_pkg::SIZE_DWORD: ok = (a[2:0] == 3'h0);
      atsap_pkg::SIZE_WORD:  ok = (len == atsap_pkg::LEN_SINGLE) && (a[1:0] == 2'h0);
      atsap_pkg::SIZE_HALF:  ok = (len == atsap_pkg::LEN_SINGLE) && !a[0];
      atsap_pkg::SIZE_BYTE:  ok = (len == atsap_pkg::LEN_SINGLE);
      default:               ok = 1'b0;
    endcase
    if (a >= ADDR_W'(1 << RAM_AW)) ok = 1'b0;
    if (sel[atsap_pkg::SEL_P1_BIT] && !P1_PRESENT) ok = 1'b0;
    return ok;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  atsap_pkg::atsap_state_t state_reg, state_next;
  logic [ID_W-1:0]   id_reg, id_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [3:0]        len_reg, len_next;
  logic [3:0]        cnt_reg, cnt_next;
  logic [2:0]        size_reg, size_next;
  logic [1:0]        burst_reg, burst_next;
  logic [1:0]        sel_reg, sel_next;
  logic              err_reg, err_next;
  logic [1:0]        slow_reg, slow_next;
  logic [63:0]       rdata_reg, rdata_next;
  logic              rlast_reg, rlast_next;
  logic              rvalid_reg, rvalid_next;
  logic              bvalid_reg, bvalid_next;
  logic              rd_issue;
  logic              wr_go;
  logic              slow;
  logic [63:0]       ram_rd_mux;
  logic [ADDR_W-1:0] addr_inc;
  logic [ADDR_W-1:0] wrap_mask;

  // Core traffic on the chosen RAM stalls this port
  wire core_hit = ram_core_busy[sel_reg];

  always_comb begin
    unique case (sel_reg)
      atsap_pkg::SEL_P0_INSTR: ram_rd_mux = ram_rdata0;
      atsap_pkg::SEL_P0_DATA:  ram_rd_mux = ram_rdata1;
      atsap_pkg::SEL_P1_INSTR: ram_rd_mux = ram_rdata2;
      atsap_pkg::SEL_P1_DATA:  ram_rd_mux = ram_rdata3;
    endcase
  end

  // Narrow or partial accesses, except word reads and low- or high-word writes to the data RAMs, pay an extra read-modify style cycle
  always_comb begin
    slow = 1'b0;
    if (size_reg != atsap_pkg::SIZE_DWORD) slow = 1'b1;
    if (state_reg == atsap_pkg::ST_WDATA && size_reg == atsap_pkg::SIZE_DWORD &&
        wstrb != atsap_pkg::STRB_FULL) slow = 1'b1;
    if (size_reg == atsap_pkg::SIZE_WORD && sel_reg[0] &&
        (state_reg != atsap_pkg::ST_WDATA ||
         wstrb == atsap_pkg::STRB_LO_WORD || wstrb == atsap_pkg::STRB_HI_WORD))
      slow = 1'b0;
  end

  always_comb begin
    wrap_mask = ADDR_W'({len_reg, 3'h7});
    addr_inc  = addr_reg + ADDR_W'(8);
    if (burst_reg == atsap_pkg::BURST_FIXED) addr_inc = addr_reg;
    if (burst_reg == atsap_pkg::BURST_WRAP)
      addr_inc = (addr_reg & ~wrap_mask) | ((addr_reg + ADDR_W'(8)) & wrap_mask);
  end

  // ------------------------------------------------------------
  // Transfer sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    id_next     = id_reg;
    addr_next   = addr_reg;
    len_next    = len_reg;
    cnt_next    = cnt_reg;
    size_next   = size_reg;
    burst_next  = burst_reg;
    sel_next    = sel_reg;
    err_next    = err_reg;
    slow_next   = slow_reg;
    rdata_next  = rdata_reg;
    rlast_next  = rlast_reg;
    rvalid_next = rvalid_reg;
    bvalid_next = bvalid_reg;
    rd_issue    = 1'b0;
    wr_go       = 1'b0;
    unique case (state_reg)
      atsap_pkg::ST_IDLE: begin
        if (arvalid) begin
          id_next = arid;  addr_next = araddr; len_next = arlen;
          size_next = arsize; burst_next = arburst; sel_next = read_target_select;
          err_next = !acc_ok(araddr, arlen, arsize, read_target_select);
          cnt_next = 4'h0; slow_next = 2'h0;
          state_next = atsap_pkg::ST_RWAIT;
        end else if (awvalid) begin
          id_next = awid;  addr_next = awaddr; len_next = awlen;
          size_next = awsize; burst_next = awburst; sel_next = write_target_select;
          err_next = !acc_ok(awaddr, awlen, awsize, write_target_select);
          cnt_next = 4'h0; slow_next = 2'h0;
          state_next = atsap_pkg::ST_WDATA;
        end
      end
      atsap_pkg::ST_RWAIT: begin
        if (err_reg) begin
          rdata_next  = 64'h0;
          rlast_next  = (cnt_reg == len_reg);
          rvalid_next = 1'b1;
          state_next  = atsap_pkg::ST_RDATA;
        end else if (!core_hit) begin
          if (slow && slow_reg != 2'(atsap_pkg::SLOW_CYCLES - 1)) begin
            slow_next = slow_reg + 2'h1;
          end else begin
            rd_issue   = 1'b1;
            slow_next  = 2'h0;
            state_next = atsap_pkg::ST_RDATA;
            rlast_next = (cnt_reg == len_reg);
          end
        end
      end
      atsap_pkg::ST_RDATA: begin
        if (!rvalid_reg) begin
          rdata_next  = ram_rd_mux;
          rvalid_next = 1'b1;
        end else if (rready) begin
          rvalid_next = 1'b0;
          if (rlast_reg) begin
            state_next = atsap_pkg::ST_IDLE;
          end else begin
            cnt_next   = cnt_reg + 4'h1;
            addr_next  = addr_inc;
            state_next = atsap_pkg::ST_RWAIT;
          end
        end
      end
      atsap_pkg::ST_WDATA: begin
        if (wvalid && (err_reg || (!core_hit &&
            (!slow || slow_reg == 2'(atsap_pkg::SLOW_CYCLES - 1))))) begin
          wr_go     = !err_reg;
          slow_next = 2'h0;
          addr_next = addr_inc;
          if (wlast) begin
            bvalid_next = 1'b1;
            state_next  = atsap_pkg::ST_WRESP;
          end
        end else if (wvalid && !core_hit && slow) begin
          slow_next = slow_reg + 2'h1;
        end
      end
      atsap_pkg::ST_WRESP: begin
        if (bready) begin
          bvalid_next = 1'b0;
          state_next  = atsap_pkg::ST_IDLE;
        end
      end
      default: state_next = atsap_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg  <= atsap_pkg::ST_IDLE;
      id_reg     <= '0;
      addr_reg   <= '0;
      len_reg    <= 4'h0;
      cnt_reg    <= 4'h0;
      size_reg   <= 3'h0;
      burst_reg  <= 2'h0;
      sel_reg    <= 2'h0;
      err_reg    <= 1'b0;
      slow_reg   <= 2'h0;
      rdata_reg  <= 64'h0;
      rlast_reg  <= 1'b0;
      rvalid_reg <= 1'b0;
      bvalid_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg  <= state_next;
      id_reg     <= id_next;
      addr_reg   <= addr_next;
      len_reg    <= len_next;
      cnt_reg    <= cnt_next;
      size_reg   <= size_next;
      burst_reg  <= burst_next;
      sel_reg    <= sel_next;
      err_reg    <= err_next;
      slow_reg   <= slow_next;
      rdata_reg  <= rdata_next;
      rlast_reg  <= rlast_next;
      rvalid_reg <= rvalid_next;
      bvalid_reg <= bvalid_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Reads win over writes in idle; one transfer in flight at a time
  assign arready   = clk_en && (state_reg == atsap_pkg::ST_IDLE);
  assign awready   = clk_en && (state_reg == atsap_pkg::ST_IDLE) && !arvalid;
  assign wready    = clk_en && (state_next != state_reg || wr_go || err_reg) &&
                     (state_reg == atsap_pkg::ST_WDATA) && wvalid &&
                     slow_next == 2'h0;
  assign rvalid    = rvalid_reg;
  assign rdata     = rdata_reg;
  assign rlast     = rlast_reg;
  assign rid       = id_reg;
  // Exclusive reads are plain reads, so OKAY never EXOKAY
  assign rresp     = err_reg ? atsap_pkg::RESP_SLVERR : atsap_pkg::RESP_OKAY;
  assign bvalid    = bvalid_reg;
  assign bid       = id_reg;
  assign bresp     = err_reg ? atsap_pkg::RESP_SLVERR : atsap_pkg::RESP_OKAY;
  assign ram_addr  = addr_reg[RAM_AW-1:3];
  assign ram_wdata = wdata;
  assign ram_wstrb = wstrb;
  // No protection lookup sits on the RAM enables
  assign ram_en    = (clk_en && (rd_issue || (wr_go && wready))) ?
                     (4'h1 << sel_reg) : 4'h0;
  assign ram_we    = (clk_en && wr_go && wready) ? (4'h1 << sel_reg) : 4'h0;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_err_read_resp: assert property (rvalid && err_reg |->
      rresp == 2'h2 && rlast == (cnt_reg == len_reg))
    else $error("errored read beat malformed");
  a_no_exokay: assert property (rvalid |-> rresp != 2'h1)
    else $error("EXOKAY returned");
  a_p1_absent: assert property ((state_reg == atsap_pkg::ST_IDLE && arvalid &&
      read_target_select[1] && !P1_PRESENT && clk_en) |=> err_reg)
    else $error("absent processor not rejected");
  a_core_prio: assert property (ram_en != 4'h0 |-> (ram_en & ram_core_busy) == 4'h0)
    else $error("port used RAM during core access");
  a_err_no_write: assert property (err_reg |-> ram_we == 4'h0)
    else $error("errored write reached RAM");
  a_narrow_burst: assert property ((state_reg == atsap_pkg::ST_IDLE && arvalid &&
      clk_en && arsize != 3'h3 && arlen != 4'h0) |=> err_reg)
    else $error("narrow burst accepted");
  a_range_error: assert property ((state_reg == atsap_pkg::ST_IDLE && arvalid &&
      clk_en && araddr >= ADDR_W'(1 << RAM_AW)) |=> err_reg)
    else $error("out of range accepted");
  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before ready");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  a_dword_ok: assert property ((state_reg == atsap_pkg::ST_IDLE && arvalid && clk_en &&
      arsize == 3'h3 && araddr[2:0] == 3'h0 && araddr < ADDR_W'(1 << RAM_AW) &&
      !read_target_select[1]) |=> !err_reg)
    else $error("aligned doubleword rejected");
  c_read_burst: cover property (rvalid && rready && rlast && len_reg != 4'h0);
  c_err_write: cover property (bvalid && bresp == 2'h2);
  c_stall: cover property (state_reg == atsap_pkg::ST_RWAIT && core_hit);
endmodule

// ---- verilog/atsap_pkg.sv ----
// Constants for the local RAM slave access port.
// Assumes one clock domain and a 64-bit slave data path.
package atsap_pkg;
  // ------------------------------------------------------------
  // Response codes
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // Transfer sizes and lengths
  // ------------------------------------------------------------
  localparam logic [2:0] SIZE_BYTE   = 3'h0;
  localparam logic [2:0] SIZE_HALF   = 3'h1;
  localparam logic [2:0] SIZE_WORD   = 3'h2;
  localparam logic [2:0] SIZE_DWORD  = 3'h3;
  localparam logic [3:0] LEN_SINGLE  = 4'h0;
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_INCR  = 2'h1;
  localparam logic [1:0] BURST_WRAP  = 2'h2;
  // ------------------------------------------------------------
  // Target select codes
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_P0_INSTR = 2'h0;
  localparam logic [1:0] SEL_P0_DATA  = 2'h1;
  localparam logic [1:0] SEL_P1_INSTR = 2'h2;
  localparam logic [1:0] SEL_P1_DATA  = 2'h3;
  localparam int         SEL_P1_BIT   = 1;
  // ------------------------------------------------------------
  // Strobe patterns and widths
  // ------------------------------------------------------------
  localparam logic [7:0] STRB_FULL    = 8'hff;
  localparam logic [7:0] STRB_LO_WORD = 8'h0f;
  localparam logic [7:0] STRB_HI_WORD = 8'hf0;
  localparam int         DATA_W       = 64;
  localparam int         STRB_W       = 8;
  localparam int         SLOW_CYCLES  = 2;
  // ------------------------------------------------------------
  // Port state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RDATA = 3'b001,
    ST_WDATA = 3'b010,
    ST_WRESP = 3'b011,
    ST_RWAIT = 3'b100
  } atsap_state_t;
endpackage

// ---- tb/atsap_ram_model.sv ----
// Behavioural model of the four local RAMs behind the slave port.
// Assumes one-cycle read latency and byte write strobes from the port.
module atsap_ram_model (
  input  wire logic        clk,
  input  wire logic [3:0]  ram_en,
  input  wire logic [3:0]  ram_we,
  input  wire logic [9:0]  ram_addr,
  input  wire logic [63:0] ram_wdata,
  input  wire logic [7:0]  ram_wstrb,
  output logic [255:0]     q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0]  mem [4][1024];
  logic [255:0] q_reg = 256'h0;
  assign q = q_reg;
  initial foreach (mem[s, a]) mem[s][a] = 64'h0;
  // --------
  // Storage
  // --------
  always @(posedge clk) begin
    for (int s = 0; s < 4; s++) begin
      if (ram_en[s] && ram_we[s]) begin
        for (int b = 0; b < 8; b++) begin
          if (ram_wstrb[b]) begin
            mem[s][ram_addr][8*b+:8] <= ram_wdata[8*b+:8];
          end
        end
      end
      // Idle outputs toggle, so data sampled a cycle late never matches
      q_reg[64*s+:64] <= (ram_en[s] && !ram_we[s]) ? mem[s][ram_addr] : ~q_reg[64*s+:64];
    end
  end
endmodule

// ---- tb/axi_tcm_slave_access_port_test.sv ----
// Self-checking bench for the local RAM slave access port.
// Assumes the RAM model is compiled first and one 50 MHz clock.
module axi_tcm_slave_access_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Signals
  // --------
  logic        clk = 1'b0, sys_rst = 1'b1, awvalid = 1'b0, arvalid = 1'b0;
  logic        wvalid = 1'b0, wlast = 1'b0, bready = 1'b0, rready = 1'b0;
  logic [3:0]  awid = 4'h0, arid = 4'h0, awlen = 4'h0, arlen = 4'h0, ram_core_busy = 4'h0;
  logic [31:0] awaddr = 32'h0, araddr = 32'h0, seed = 32'h00010df7;
  logic [2:0]  awsize = 3'h0, arsize = 3'h0;
  logic [1:0]  awburst = 2'h0, arburst = 2'h0;
  logic [1:0]  write_target_select = 2'h0, read_target_select = 2'h0;
  logic [63:0] wdata = 64'h0, rdata, ram_wdata;
  logic [7:0]  wstrb = 8'h0, ram_wstrb;
  logic        awready, wready, bvalid, arready, rlast, rvalid;
  logic [3:0]  bid, rid, ram_en, ram_we;
  logic [1:0]  bresp, rresp;
  logic [9:0]  ram_addr;
  logic [255:0] q;
  logic [63:0] ref_mem [4][1024];
  int          n_fail = 0, n_compared = 0, cycles = 0;
  localparam logic [31:0] BAD_A [7] = '{32'h402, 32'h401, 32'h404, 32'h400, 32'h400,
                                        32'h2000, 32'h401};
  localparam logic [2:0]  BAD_Z [7] = '{3'h2, 3'h1, 3'h3, 3'h2, 3'h4, 3'h3, 3'h0};
  localparam logic [3:0]  BAD_L [7] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h2};

  atsap_port #(.ID_W(4), .ADDR_W(32), .RAM_AW(13), .P1_PRESENT(1'b1)) i_atsap_port (
    .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .awid(awid), .awaddr(awaddr),
    .awlen(awlen), .awsize(awsize), .awburst(awburst),
    .write_target_select(write_target_select), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wlast(wlast), .wvalid(wvalid), .wready(wready),
    .bid(bid), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arid(arid),
    .araddr(araddr), .arlen(arlen), .arsize(arsize), .arburst(arburst),
    .read_target_select(read_target_select), .arvalid(arvalid), .arready(arready),
    .rid(rid), .rdata(rdata), .rresp(rresp), .rlast(rlast), .rvalid(rvalid),
    .rready(rready), .ram_core_busy(ram_core_busy), .ram_en(ram_en), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_wstrb(ram_wstrb),
    .ram_rdata0(q[63:0]), .ram_rdata1(q[127:64]), .ram_rdata2(q[191:128]),
    .ram_rdata3(q[255:192]));
  atsap_ram_model i_atsap_ram_model (.clk(clk), .ram_en(ram_en), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_wstrb(ram_wstrb), .q(q));
  // --------
  // Helpers
  // --------
  always #10 clk = ~clk;
  initial foreach (ref_mem[s, a]) ref_mem[s][a] = 64'h0;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic ok_fn(input logic [31:0] a, input logic [2:0] z,
                                 input logic [3:0] n);
    return z <= 3'h3 && (z == 3'h3 || n == 4'h0) && (a & ((32'h1 << z) - 1)) == 0
           && a < 32'h2000;
  endfunction
  function automatic logic [31:0] beat_a(input logic [31:0] a, input logic [1:0] bt,
                                         input logic [3:0] n, input int i);
    logic [31:0] m;
    m = ({28'h0, n} + 1) * 8 - 1;
    if (bt == atsap_pkg::BURST_FIXED) return a;
    if (bt == atsap_pkg::BURST_WRAP) return (a & ~m) | ((a + 8 * i) & m);
    return a + 8 * i;
  endfunction
  function automatic logic [63:0] lanes(input logic [31:0] a, input logic [2:0] z);
    return (z == 3'h3) ? 64'hffffffffffffffff : ((64'h1 << (8 << z)) - 1) << (8 * a[2:0]);
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Random stalls on both answer channels and the core side
  always @(posedge clk) begin
    seed          <= lfsr(seed);
    ram_core_busy <= seed[3:0] & seed[7:4];
    rready        <= seed[9] | seed[10];
    bready        <= seed[11] | seed[12];
    cycles        <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  always @(negedge clk) begin
    if (!sys_rst) chk({60'h0, ram_en & ram_core_busy}, 64'h0);
  end
  // --------
  // Bus tasks
  // --------
  task automatic wr(input logic [1:0] sel, input logic [31:0] a, input logic [2:0] z,
                    input logic [3:0] n, input logic [1:0] bt, input logic [7:0] st);
    logic        ok;
    logic [31:0] ba;
    ok = ok_fn(a, z, n);
    @(posedge clk);
    awid <= awid + 4'h1;
    awaddr <= a;
    awsize <= z;
    awlen <= n;
    awburst <= bt;
    write_target_select <= sel;
    // Plain writes only: no write ever follows an exclusive read
    awvalid <= 1'b1;
    do @(posedge clk); while (!awready);
    awvalid <= 1'b0;
    for (int i = 0; i <= int'(n); i++) begin
      wdata <= {seed, ~seed};
      wstrb <= st;
      wlast <= (i == int'(n));
      wvalid <= 1'b1;
      do @(posedge clk); while (!wready);
      ba = beat_a(a, bt, n, i);
      for (int b = 0; b < 8; b++) begin
        if (ok && wstrb[b]) ref_mem[sel][ba[12:3]][8*b+:8] = wdata[8*b+:8];
      end
    end
    wvalid <= 1'b0;
    do @(posedge clk); while (!(bvalid && bready));
    chk({62'h0, bresp}, ok ? 64'h0 : 64'h2);
    chk({60'h0, bid}, {60'h0, awid});
  endtask
  task automatic rd(input logic [1:0] sel, input logic [31:0] a, input logic [2:0] z,
                    input logic [3:0] n, input logic [1:0] bt);
    logic        ok;
    logic [31:0] ba;
    ok = ok_fn(a, z, n);
    @(posedge clk);
    arid <= arid + 4'h1;
    araddr <= a;
    arsize <= z;
    arlen <= n;
    arburst <= bt;
    read_target_select <= sel;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    for (int i = 0; i <= int'(n); i++) begin
      do @(posedge clk); while (!(rvalid && rready));
      ba = beat_a(a, bt, n, i);
      chk({61'h0, rlast, rresp}, {61'h0, i == int'(n), ok ? 2'h0 : 2'h2});
      chk({60'h0, rid}, {60'h0, arid});
      if (ok) chk(rdata & lanes(a, z), ref_mem[sel][ba[12:3]] & lanes(a, z));
    end
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    logic [31:0] a;
    logic [63:0] m;
    logic [7:0]  st;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      a = 32'h100 + 32'h40 * s;
      wr(s[1:0], a, atsap_pkg::SIZE_DWORD, 4'h3, atsap_pkg::BURST_INCR, 8'hff);
      rd(s[1:0], a, atsap_pkg::SIZE_DWORD, 4'h3, atsap_pkg::BURST_INCR);
    end
    wr(2'h1, 32'h218, atsap_pkg::SIZE_DWORD, 4'h3, atsap_pkg::BURST_WRAP, 8'hff);
    rd(2'h1, 32'h200, atsap_pkg::SIZE_DWORD, 4'h3, atsap_pkg::BURST_INCR);
    rd(2'h1, 32'h218, atsap_pkg::SIZE_DWORD, 4'h3, atsap_pkg::BURST_WRAP);
    wr(2'h2, 32'h300, atsap_pkg::SIZE_DWORD, 4'h1, atsap_pkg::BURST_FIXED, 8'h3c);
    rd(2'h2, 32'h300, atsap_pkg::SIZE_DWORD, 4'h1, atsap_pkg::BURST_FIXED);
    wr(2'h3, 32'h1f80, atsap_pkg::SIZE_DWORD, 4'hf, atsap_pkg::BURST_INCR, 8'hff);
    rd(2'h3, 32'h1f80, atsap_pkg::SIZE_DWORD, 4'hf, atsap_pkg::BURST_INCR);
    wr(2'h1, 32'h408, atsap_pkg::SIZE_WORD, 4'h0, atsap_pkg::BURST_INCR, 8'h0f);
    wr(2'h0, 32'h408, atsap_pkg::SIZE_WORD, 4'h0, atsap_pkg::BURST_FIXED, 8'h06);
    rd(2'h0, 32'h408, atsap_pkg::SIZE_WORD, 4'h0, atsap_pkg::BURST_FIXED);
    // Narrow singles with a random, possibly reserved, burst type
    for (int s = 0; s < 2; s++) begin
      for (int z = 0; z < 3; z++) begin
        a = 32'h408 | (32'h4 >> (2 - z));
        m = lanes(a, 3'(z));
        for (int b = 0; b < 8; b++) st[b] = m[8*b];
        wr(s[1:0], a, 3'(z), 4'h0, seed[1:0], st);
        rd(s[1:0], a, 3'(z), 4'h0, seed[3:2]);
      end
    end
    for (int k = 0; k < 7; k++) begin
      wr(2'(k), BAD_A[k], BAD_Z[k], BAD_L[k], atsap_pkg::BURST_INCR, 8'hff);
      rd(2'(k), BAD_A[k], BAD_Z[k], BAD_L[k], atsap_pkg::BURST_INCR);
    end
    for (int s = 0; s < 4; s++) begin
      rd(s[1:0], 32'h0, atsap_pkg::SIZE_DWORD, 4'h0, atsap_pkg::BURST_INCR);
      rd(s[1:0], 32'h400, atsap_pkg::SIZE_DWORD, 4'h1, atsap_pkg::BURST_INCR);
    end
    results();
  end
endmodule
